// ==== core/reset_strap_config_latch.sv ====
// reset strap configuration latch: samples the shared address and
// write-enable pins as the primary reset releases and holds the decode.
// assumes rst is the primary reset, held for at least three enabled edges,
// and that the pin wires carry a weak pull-up in the testbench.
`timescale 1ns/1ps
`default_nettype none

module reset_strap_config_latch (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [strap_cfg_pkg::ADDR_W-1:0] periph_addr_in,
   input wire logic periph_write_enable_n_in,
   output logic [strap_cfg_pkg::ADDR_W-1:0] periph_addr_out,
   output logic periph_write_enable_n_out,
   output logic periph_pins_oe,
   input wire strap_cfg_pkg::periph_pins_t core_pins,
   input wire logic linkdown_event,
   output logic full_reset_req,
   output logic cfg_valid,
   output strap_cfg_pkg::strap_cfg_t cfg
);
   import strap_cfg_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // pin synchroniser
   // no reset here so the pins are already settled when rst drops
   logic [STRAP_W-1:0] pin_meta_r;
   logic [STRAP_W-1:0] pin_sync_r;

   always_ff @(posedge ref_clk) begin
      if (clk_en) begin
         pin_meta_r <= {periph_write_enable_n_in, periph_addr_in};
         pin_sync_r <= pin_meta_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // capture on release of reset
   logic captured_r;
   strap_cfg_t cfg_r;
   strap_cfg_t cfg_nxt;
   logic full_reset_req_r;
   wire capture_go = clk_en & ~rst & ~captured_r;

   ////////////////////////////////////////////////////////////////////////
   // strap decode, one named wire per configuration field
   // straps are active low where a zero turns a feature on
   logic [6:0] slave_addr_dec;
   logic bus_pullup_dec;
   logic narrow_dec;
   logic upper_pullup_dec;
   logic speed_full_dec;
   logic hot_insert_dec;
   logic fw_timer_dec;
   logic raid_dec;
   logic pll_bus_clk_dec;
   logic linkdown_reset_dec;

   // bits 6, 4 and 0 have no strap and stay at the fixed base
   assign slave_addr_dec = {SLAVE_ADDR_BASE[6], pin_sync_r[PIN_SLAVE_A5], SLAVE_ADDR_BASE[4],
      pin_sync_r[PIN_SLAVE_A3], pin_sync_r[PIN_SLAVE_A2], pin_sync_r[PIN_SLAVE_A1],
      SLAVE_ADDR_BASE[0]};
   assign bus_pullup_dec = ~pin_sync_r[PIN_PULLUP];
   assign narrow_dec = ~pin_sync_r[PIN_NARROW];
   // a narrow bus leaves its upper lanes open, so they keep pull-ups
   assign upper_pullup_dec = bus_pullup_dec | narrow_dec;
   assign speed_full_dec = pin_sync_r[PIN_SPEED_CAP];
   assign hot_insert_dec = ~pin_sync_r[PIN_HOT_INSERT];
   assign fw_timer_dec = pin_sync_r[PIN_FW_TIMER];
   assign raid_dec = pin_sync_r[PIN_CTRL_ONLY];
   assign pll_bus_clk_dec = pin_sync_r[PIN_PLL_SRC];
   assign linkdown_reset_dec = pin_sync_r[PIN_LINKDOWN];

   assign cfg_nxt = '{slave_addr: slave_addr_dec, bus_pullup_en: bus_pullup_dec,
      upper_pullup_en: upper_pullup_dec, bus_64bit: ~narrow_dec,
      mode1_133_allowed: speed_full_dec, hot_insert_en: hot_insert_dec,
      fw_timer_en: fw_timer_dec, raid_enabled: raid_dec,
      pll_from_bus_clk: pll_bus_clk_dec, linkdown_full_reset: linkdown_reset_dec};

   // reset waits for the enable too, so a frozen block keeps its state
   always_ff @(posedge ref_clk) begin
      if (clk_en && rst) begin
         captured_r <= 1'b0;
         cfg_r <= CFG_RESET;
      end else if (capture_go) begin
         captured_r <= 1'b1;
         cfg_r <= cfg_nxt;
      end
   end

   // link-down reset request, gated by the captured skip strap
   always_ff @(posedge ref_clk) begin
      if (clk_en) begin
         if (rst) begin
            full_reset_req_r <= 1'b0;
         end else begin
            full_reset_req_r <= linkdown_event & cfg_r.linkdown_full_reset;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // shared pins go back to normal use only after capture
   // holding the drivers off until then keeps the straps readable
   wire pins_free = captured_r & core_pins.drive;

   assign periph_pins_oe = pins_free;
   assign periph_addr_out = core_pins.addr;
   assign periph_write_enable_n_out = core_pins.write_enable_n;
   assign cfg = cfg_r;
   assign cfg_valid = captured_r;
   assign full_reset_req = full_reset_req_r;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_capture;
      capture_go;
   endsequence

   sequence s_pin_held(logic [STRAP_W-1:0] v);
      pin_sync_r == v;
   endsequence

   sequence s_release;
      $fell(rst) && clk_en;
   endsequence

   a_capture_once: assert property (
      s_capture |=> captured_r && cfg_r == decode_straps($past(pin_sync_r)))
      else $error("configuration not taken from pins at reset release");

   a_capture_follows_release: assert property (
      $fell(rst) && clk_en |=> captured_r)
      else $error("straps not captured on first enabled edge after reset");

   a_cfg_held: assert property (
      captured_r |=> $stable(cfg_r) && captured_r)
      else $error("latched configuration changed after capture");

   a_slave_addr_bits: assert property (
      s_capture |=> cfg.slave_addr[5] == $past(pin_sync_r[PIN_SLAVE_A5])
         && cfg.slave_addr[3] == $past(pin_sync_r[PIN_SLAVE_A3])
         && cfg.slave_addr[2] == $past(pin_sync_r[PIN_SLAVE_A2])
         && cfg.slave_addr[1] == $past(pin_sync_r[PIN_SLAVE_A1]))
      else $error("slave address bits do not match straps");

   a_pullup_select: assert property (
      s_capture |=> cfg.bus_pullup_en == !$past(pin_sync_r[PIN_PULLUP]))
      else $error("bus pull-up enable has wrong sense");

   a_width_select: assert property (
      s_capture |=> cfg.bus_64bit == $past(pin_sync_r[PIN_NARROW]))
      else $error("bus width does not follow strap");

   a_narrow_pullups: assert property (
      cfg_valid && !cfg.bus_64bit |-> cfg.upper_pullup_en)
      else $error("upper pull-ups off in 32-bit mode");

   a_speed_cap: assert property (
      s_capture |=> cfg.mode1_133_allowed == $past(pin_sync_r[PIN_SPEED_CAP]))
      else $error("mode 1 speed cap has wrong sense");

   a_hot_insert: assert property (
      s_capture |=> cfg.hot_insert_en == !$past(pin_sync_r[PIN_HOT_INSERT]))
      else $error("hot-swap startup has wrong sense");

   a_fw_timer: assert property (
      s_capture |=> cfg.fw_timer_en == $past(pin_sync_r[PIN_FW_TIMER]))
      else $error("firmware timer enable has wrong sense");

   a_ctrl_only: assert property (
      s_capture |=> cfg.raid_enabled == $past(pin_sync_r[PIN_CTRL_ONLY]))
      else $error("array function enable has wrong sense");

   a_pll_source: assert property (
      s_capture |=> cfg.pll_from_bus_clk == $past(pin_sync_r[PIN_PLL_SRC]))
      else $error("pll source does not follow write-enable strap");

   a_linkdown_gate: assert property (
      clk_en && linkdown_event |=> full_reset_req == $past(cfg_r.linkdown_full_reset))
      else $error("link-down reset request not gated by strap");

   a_no_drive_early: assert property (
      !captured_r |-> !periph_pins_oe)
      else $error("shared pins driven before straps captured");

   a_idle_default: assert property (
      s_capture ##0 s_pin_held(STRAP_IDLE) |=> cfg_r == CFG_RESET)
      else $error("floating straps do not give default configuration");

   a_fresh_after_reset: assert property (
      s_release |-> !cfg_valid)
      else $error("capture state not cleared by reset");

   a_reset_defaults: assert property (
      s_release |-> cfg_r == CFG_RESET)
      else $error("configuration not at default when reset releases");

   a_enable_freeze: assert property (
      !clk_en |=> $stable(cfg_r) && $stable(captured_r) && $stable(full_reset_req_r)
         && $stable(pin_sync_r))
      else $error("state moved while clock enable was low");

   a_linkdown_suppress: assert property (
      clk_en && !cfg_r.linkdown_full_reset |=> !full_reset_req)
      else $error("link-down reset requested although skip strap set");

   a_upper_pullup_off: assert property (
      cfg_valid && cfg.bus_64bit && !cfg.bus_pullup_en |-> !cfg.upper_pullup_en)
      else $error("upper pull-ups on with wide bus and pull-up strap high");

   a_pins_resume: assert property (
      captured_r && core_pins.drive |-> periph_pins_oe)
      else $error("shared pins not returned to normal use after capture");

endmodule // reset_strap_config_latch

`default_nettype wire

// ==== core/strap_cfg_pkg.sv ====
// package for the reset strap configuration latch: pin positions, reset
// values, carrier types and the strap decode.
// assumes straps arrive on the shared peripheral address and write-enable pins.
package strap_cfg_pkg;

   localparam int ADDR_W = 25;
   localparam int STRAP_W = ADDR_W + 1;

   // pin positions inside {write enable, address}
   localparam int PIN_SLAVE_A5 = 16;
   localparam int PIN_SLAVE_A3 = 15;
   localparam int PIN_SLAVE_A2 = 14;
   localparam int PIN_SLAVE_A1 = 13;
   localparam int PIN_PULLUP = 17;
   localparam int PIN_NARROW = 18;
   localparam int PIN_SPEED_CAP = 19;
   localparam int PIN_HOT_INSERT = 21;
   localparam int PIN_FW_TIMER = 22;
   localparam int PIN_CTRL_ONLY = 23;
   localparam int PIN_LINKDOWN = 24;
   localparam int PIN_PLL_SRC = ADDR_W;

   // floating straps read high through the internal pull-ups
   localparam logic [STRAP_W-1:0] STRAP_IDLE = 26'h3FFFFFF;

   // slave address bits that no strap sets (6, 4, 0)
   localparam logic [6:0] SLAVE_ADDR_BASE = 7'h00;

   typedef struct packed {
      logic [6:0] slave_addr;
      logic bus_pullup_en;
      logic upper_pullup_en;
      logic bus_64bit;
      logic mode1_133_allowed;
      logic hot_insert_en;
      logic fw_timer_en;
      logic raid_enabled;
      logic pll_from_bus_clk;
      logic linkdown_full_reset;
   } strap_cfg_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic write_enable_n;
      logic drive;
   } periph_pins_t;

   function automatic strap_cfg_t decode_straps(input logic [STRAP_W-1:0] s);
      strap_cfg_t c;
      c.slave_addr = SLAVE_ADDR_BASE;
      c.slave_addr[5] = s[PIN_SLAVE_A5];
      c.slave_addr[3] = s[PIN_SLAVE_A3];
      c.slave_addr[2] = s[PIN_SLAVE_A2];
      c.slave_addr[1] = s[PIN_SLAVE_A1];
      c.bus_pullup_en = ~s[PIN_PULLUP];
      c.bus_64bit = s[PIN_NARROW];
      c.upper_pullup_en = ~s[PIN_PULLUP] | ~s[PIN_NARROW];
      c.mode1_133_allowed = s[PIN_SPEED_CAP];
      c.hot_insert_en = ~s[PIN_HOT_INSERT];
      c.fw_timer_en = s[PIN_FW_TIMER];
      c.raid_enabled = s[PIN_CTRL_ONLY];
      c.pll_from_bus_clk = s[PIN_PLL_SRC];
      c.linkdown_full_reset = s[PIN_LINKDOWN];
      return c;
   endfunction

   localparam strap_cfg_t CFG_RESET = decode_straps(STRAP_IDLE);

endpackage

// ==== verif/strap_board.sv ====
// board side of the strap pins: pull-down resistors where fitted.
// assumes the device drives every shared pin while its enable is high.
`timescale 1ns/1ps
`default_nettype none

module strap_board (
   input wire logic [strap_cfg_pkg::STRAP_W-1:0] pull_down,
   input wire logic oe,
   input wire logic [strap_cfg_pkg::STRAP_W-1:0] dev_out,
   output logic [strap_cfg_pkg::STRAP_W-1:0] pin
);
   import strap_cfg_pkg::*;
   ////////////////////////////////////////////////////////////////
   // released pins fall back to the resistor level, never the last value
   assign pin = oe ? dev_out : ~pull_down;
endmodule // strap_board

`default_nettype wire

// ==== verif/tb_top.sv ====
// testbench for the reset strap configuration latch.
// assumes strap_board stands for the board resistors on the shared pins.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import strap_cfg_pkg::*;
   logic ref_clk, rst, clk_en, lnk, frr, oe, valid, we_out;
   logic [STRAP_W-1:0] pd, pins;
   logic [ADDR_W-1:0] a_out;
   periph_pins_t core;
   strap_cfg_t cfg, e;
   int n_errors, num_checks;
   logic [STRAP_W-1:0] masks [4] = '{26'h0000000, 26'h3FFFFFF, 26'h2AAAAAA, 26'h1555555};

   strap_board i_board (.pull_down(pd), .oe(oe), .dev_out({we_out, a_out}), .pin(pins));
   reset_strap_config_latch i_dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
      .periph_addr_in(pins[ADDR_W-1:0]), .periph_write_enable_n_in(pins[PIN_PLL_SRC]),
      .periph_addr_out(a_out), .periph_write_enable_n_out(we_out), .periph_pins_oe(oe),
      .core_pins(core), .linkdown_event(lnk), .full_reset_req(frr), .cfg_valid(valid),
      .cfg(cfg));

   ////////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // expected decode, built field by field from the strap levels
   function automatic strap_cfg_t exp_of(input logic [STRAP_W-1:0] s);
      strap_cfg_t c;
      c = '0;
      c.slave_addr[5] = s[PIN_SLAVE_A5];
      c.slave_addr[3] = s[PIN_SLAVE_A3];
      c.slave_addr[2] = s[PIN_SLAVE_A2];
      c.slave_addr[1] = s[PIN_SLAVE_A1];
      c.bus_pullup_en = ~s[PIN_PULLUP];
      c.bus_64bit = s[PIN_NARROW];
      c.upper_pullup_en = ~s[PIN_PULLUP] | ~s[PIN_NARROW];
      c.mode1_133_allowed = s[PIN_SPEED_CAP];
      c.hot_insert_en = ~s[PIN_HOT_INSERT];
      c.fw_timer_en = s[PIN_FW_TIMER];
      c.raid_enabled = s[PIN_CTRL_ONLY];
      c.pll_from_bus_clk = s[PIN_PLL_SRC];
      c.linkdown_full_reset = s[PIN_LINKDOWN];
      return c;
   endfunction

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic stop_test();
      if (n_errors == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      clk_en = 1'b1;
      lnk = 1'b0;
      pd = '0;
      core = '0;
      n_errors = 0;
      num_checks = 0;
      tick(2);
      foreach (masks[i]) begin
         // straps held through reset; pins settle before release
         pd = masks[i];
         rst = 1'b1;
         core = '0;
         tick(3);
         check(32'(valid), 32'h0);
         check(32'(oe), 32'h0);
         check(32'(cfg), 32'(exp_of(STRAP_IDLE)));
         rst = 1'b0;
         tick(1);
         e = exp_of(~masks[i]);
         check(32'(cfg), 32'(e));
         check(32'(valid), 32'h1);
         // device takes the pins back with the opposite levels
         core = '{addr: ~pins[ADDR_W-1:0], write_enable_n: ~pins[PIN_PLL_SRC], drive: 1'b1};
         tick(4);
         check(32'(pins), 32'({core.write_enable_n, core.addr}));
         check(32'(cfg), 32'(e));
         lnk = 1'b1;
         tick(1);
         check(32'(frr), 32'(e.linkdown_full_reset));
         lnk = 1'b0;
         tick(1);
         check(32'(frr), 32'h0);
      end
      // enable low freezes everything, capture and link-down request included
      pd = masks[2];
      rst = 1'b1;
      core = '0;
      tick(3);
      clk_en = 1'b0;
      rst = 1'b0;
      lnk = 1'b1;
      tick(2);
      check(32'(valid), 32'h0);
      check(32'(cfg), 32'(exp_of(STRAP_IDLE)));
      check(32'(frr), 32'h0);
      clk_en = 1'b1;
      lnk = 1'b0;
      tick(1);
      check(32'(valid), 32'h1);
      check(32'(cfg), 32'(exp_of(~masks[2])));
      stop_test();
   end
endmodule // tb_top

`default_nettype wire
